/* verilog/pixel_unpack.sv */
// Receive pixel unpacker: lane entry sequencing, settle timers, format packing, APB registers
`timescale 1ns/1ps

module pixel_unpack (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pixel_unpack_pkg::lane_pins_t lane_pins,
   output pixel_unpack_pkg::pixel_bus_t pixel_out
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Stage one feeds stage two only; stage three exists for link clock edge finding
   pixel_unpack_pkg::lane_pins_t sync1;
   pixel_unpack_pkg::lane_pins_t pins;
   logic link_clk_prev;
   logic link_rise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= '{1'b0, 1'b0, 2'h3, 2'h3};
         pins <= '{1'b0, 1'b0, 2'h3, 2'h3};
         link_clk_prev <= 1'b0;
      end else begin
         sync1 <= lane_pins;
         pins <= sync1;
         link_clk_prev <= pins.link_clk;
      end
   end

   assign link_rise = pins.link_clk & ~link_clk_prev;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [5:0] format_code;
   logic [11:0] clk_settle_ns;
   logic [11:0] data_settle_ns;
   logic [5:0] next_format_code;
   logic [11:0] next_clk_settle_ns;
   logic [11:0] next_data_settle_ns;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] status_word;
   logic mapped;
   logic commit;

   // Clamp written settle times into the supported range
   function automatic logic [11:0] clamp_settle(input logic [31:0] v);
      logic [11:0] r;
      r = v[11:0];
      if (v > {20'h00000, pixel_unpack_pkg::SETTLE_MAX_NS}) begin
         r = pixel_unpack_pkg::SETTLE_MAX_NS;
      end else if (v < {20'h00000, pixel_unpack_pkg::SETTLE_MIN_NS}) begin
         r = pixel_unpack_pkg::SETTLE_MIN_NS;
      end
      return r;
   endfunction

   always_comb begin
      next_format_code = format_code;
      next_clk_settle_ns = clk_settle_ns;
      next_data_settle_ns = data_settle_ns;
      next_prdata = 32'h00000000;
      next_pready = psel & ~penable;
      next_pslverr = 1'b0;
      mapped = 1'b1;
      unique case (paddr)
         pixel_unpack_pkg::ADDR_FORMAT: next_prdata = {26'h0000000, format_code};
         pixel_unpack_pkg::ADDR_CLK_SETTLE: next_prdata = {20'h00000, clk_settle_ns};
         pixel_unpack_pkg::ADDR_DATA_SETTLE: next_prdata = {20'h00000, data_settle_ns};
         pixel_unpack_pkg::ADDR_STATUS: next_prdata = status_word;
         default: mapped = 1'b0;
      endcase
      // Answer is prepared in the setup cycle; zero wait states
      next_pslverr = psel & ~penable & ~mapped;
      // Read data only for reads, so a write access never shows register contents
      if (!(psel & ~penable & ~pwrite)) begin
         next_prdata = 32'h00000000;
      end
      commit = psel & penable & pready & pwrite & ~pslverr;
      if (commit) begin
         unique case (paddr)
            pixel_unpack_pkg::ADDR_FORMAT: next_format_code = pwdata[5:0];
            pixel_unpack_pkg::ADDR_CLK_SETTLE: next_clk_settle_ns = clamp_settle(pwdata);
            pixel_unpack_pkg::ADDR_DATA_SETTLE: next_data_settle_ns = clamp_settle(pwdata);
            default: next_format_code = format_code;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         format_code <= pixel_unpack_pkg::FORMAT_RESET;
         clk_settle_ns <= pixel_unpack_pkg::CLK_SETTLE_RESET;
         data_settle_ns <= pixel_unpack_pkg::DATA_SETTLE_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         format_code <= next_format_code;
         clk_settle_ns <= next_clk_settle_ns;
         data_settle_ns <= next_data_settle_ns;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ------------------------------------------------------------
   // Lane state machines, index 0 clock lane, index 1 data lane
   // ------------------------------------------------------------
   pixel_unpack_pkg::lane_state_t lane_state [2];
   logic [1:0] lane_hs;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_lane
         pixel_unpack_pkg::lane_state_t next_state;
         logic [11:0] elapsed_ns;
         logic [11:0] next_elapsed_ns;
         logic [1:0] lp;
         logic [11:0] settle_ns;

         assign lp = (g == 0) ? pins.clk_lp : pins.dat_lp;
         assign settle_ns = (g == 0) ? clk_settle_ns : data_settle_ns;

         always_comb begin
            next_state = lane_state[g];
            next_elapsed_ns = elapsed_ns;
            unique case (lane_state[g])
               pixel_unpack_pkg::lane_stop: begin
                  if (lp == pixel_unpack_pkg::LP_01) begin
                     next_state = pixel_unpack_pkg::lane_request;
                  end
               end
               pixel_unpack_pkg::lane_request: begin
                  // Settle time runs from the start of the prepare state
                  if (lp == pixel_unpack_pkg::LP_00) begin
                     next_state = pixel_unpack_pkg::lane_settle;
                     next_elapsed_ns = 12'h000;
                  end else if (lp != pixel_unpack_pkg::LP_01) begin
                     next_state = pixel_unpack_pkg::lane_stop;
                  end
               end
               pixel_unpack_pkg::lane_settle: begin
                  // Prepare and zero periods are the transmitter's; we only wait
                  if (lp == pixel_unpack_pkg::LP_11) begin
                     next_state = pixel_unpack_pkg::lane_stop;
                  end else if (elapsed_ns >= settle_ns) begin
                     next_state = pixel_unpack_pkg::lane_hs;
                  end else begin
                     next_elapsed_ns = elapsed_ns + pixel_unpack_pkg::CLK_PERIOD_NS;
                  end
               end
               pixel_unpack_pkg::lane_hs: begin
                  if (lp == pixel_unpack_pkg::LP_11) begin
                     next_state = pixel_unpack_pkg::lane_stop;
                  end
               end
               default: next_state = pixel_unpack_pkg::lane_stop;
            endcase
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lane_state[g] <= pixel_unpack_pkg::lane_stop;
               elapsed_ns <= 12'h000;
            end else begin
               lane_state[g] <= next_state;
               elapsed_ns <= next_elapsed_ns;
            end
         end

         assign lane_hs[g] = (lane_state[g] == pixel_unpack_pkg::lane_hs);
      end
   endgenerate

   // ------------------------------------------------------------
   // Pixel packing
   // ------------------------------------------------------------
   logic [5:0] active_code;
   logic [5:0] next_active_code;
   logic [63:0] shift;
   logic [63:0] next_shift;
   logic [6:0] bit_count;
   logic [6:0] next_bit_count;
   logic [12:0] pix_count;
   logic [12:0] next_pix_count;
   logic even_line;
   logic next_even_line;
   logic overflow;
   logic next_overflow;
   pixel_unpack_pkg::pixel_bus_t next_out;
   pixel_unpack_pkg::fmt_info_t fmt;
   logic [63:0] word_mask;
   logic [13:0] pix_after;
   logic sample;

   always_comb begin
      fmt = pixel_unpack_pkg::fmt_lookup(active_code, even_line);
      word_mask = (fmt.word_bits == 7'h40) ? 64'hFFFFFFFFFFFFFFFF :
         ((64'h0000000000000001 << fmt.word_bits[5:0]) - 64'h0000000000000001);
      pix_after = {1'b0, pix_count} + {10'h000, fmt.pixels};
      // Bits are taken only with both lanes in high speed; the clock lane leads the data lane
      sample = link_rise & lane_hs[0] & lane_hs[1];
      next_active_code = active_code;
      next_shift = shift;
      next_bit_count = bit_count;
      next_pix_count = pix_count;
      next_even_line = even_line;
      next_overflow = overflow;
      next_out = pixel_out;
      next_out.valid = 1'b0;
      next_out.hsync = lane_hs[1];
      next_out.even_line = even_line;
      next_out.pixels = fmt.pixels;
      // Cleared at line start before any set below, so an overflow in that cycle wins
      if (lane_hs[1] && !pixel_out.hsync) begin
         next_overflow = 1'b0;
      end
      if (!pixel_out.hsync) begin
         next_active_code = format_code;
      end
      if (!lane_hs[1]) begin
         // Partial words at line end are discarded
         next_bit_count = 7'h00;
         next_pix_count = 13'h0000;
         next_shift = 64'h0000000000000000;
         if (pixel_out.hsync) begin
            next_even_line = ~even_line;
         end
      end else if (sample) begin
         next_shift = {shift[62:0], pins.hs_data};
         if (bit_count + 7'h01 >= fmt.word_bits) begin
            next_bit_count = 7'h00;
            if (!pix_after[13] && pix_after[12:0] <= fmt.max_line) begin
               next_pix_count = pix_after[12:0];
               next_out.data = next_shift & word_mask;
               next_out.valid = fmt.supported;
            end else begin
               next_overflow = 1'b1;
            end
         end else begin
            next_bit_count = bit_count + 7'h01;
         end
      end
   end

   // Formats covered by the table lookup above

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_code <= pixel_unpack_pkg::FORMAT_RESET;
         shift <= 64'h0000000000000000;
         bit_count <= 7'h00;
         pix_count <= 13'h0000;
         even_line <= 1'b0;
         overflow <= 1'b0;
         pixel_out <= '0;
      end else begin
         active_code <= next_active_code;
         shift <= next_shift;
         bit_count <= next_bit_count;
         pix_count <= next_pix_count;
         even_line <= next_even_line;
         overflow <= next_overflow;
         pixel_out <= next_out;
      end
   end

   // ------------------------------------------------------------
   // Status word
   // ------------------------------------------------------------
   always_comb begin
      status_word = 32'h00000000;
      status_word[pixel_unpack_pkg::STAT_SUPPORTED] = fmt.supported;
      status_word[pixel_unpack_pkg::STAT_CLK_HS] = lane_hs[0];
      status_word[pixel_unpack_pkg::STAT_DATA_HS] = lane_hs[1];
      status_word[pixel_unpack_pkg::STAT_EVEN_LINE] = even_line;
      status_word[pixel_unpack_pkg::STAT_OVERFLOW] = overflow;
      status_word[pixel_unpack_pkg::STAT_COUNT_LSB +: 13] = pix_count;
   end

endmodule

/* verilog/pixel_unpack_pkg.sv */
// Package: constants, types and the pixel format table of the receive pixel unpacker
package pixel_unpack_pkg;

   // ------------------------------------------------------------
   // Register map and reset values
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_FORMAT = 12'h000;
   localparam logic [11:0] ADDR_CLK_SETTLE = 12'h004;
   localparam logic [11:0] ADDR_DATA_SETTLE = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [5:0] FORMAT_RESET = 6'h2A;
   localparam logic [11:0] CLK_SETTLE_RESET = 12'h0C8;
   localparam logic [11:0] DATA_SETTLE_RESET = 12'h091;

   // ------------------------------------------------------------
   // Timing, in nanoseconds
   // ------------------------------------------------------------
   localparam logic [11:0] CLK_PERIOD_NS = 12'h00A;
   localparam logic [11:0] SETTLE_MIN_NS = 12'h028;
   localparam logic [11:0] SETTLE_MAX_NS = 12'hA1E;

   // ------------------------------------------------------------
   // Low-power line states, {p, n}
   // ------------------------------------------------------------
   localparam logic [1:0] LP_11 = 2'h3;
   localparam logic [1:0] LP_01 = 2'h1;
   localparam logic [1:0] LP_00 = 2'h0;

   // ------------------------------------------------------------
   // Status register field positions
   // ------------------------------------------------------------
   localparam int STAT_SUPPORTED = 0;
   localparam int STAT_CLK_HS = 1;
   localparam int STAT_DATA_HS = 2;
   localparam int STAT_EVEN_LINE = 3;
   localparam int STAT_OVERFLOW = 4;
   localparam int STAT_COUNT_LSB = 16;

   typedef enum logic [2:0] {
      lane_stop, lane_request, lane_settle, lane_hs
   } lane_state_t;

   typedef struct packed {
      logic link_clk;
      logic hs_data;
      logic [1:0] clk_lp;
      logic [1:0] dat_lp;
   } lane_pins_t;

   typedef struct packed {
      logic valid;
      logic hsync;
      logic even_line;
      logic [3:0] pixels;
      logic [63:0] data;
   } pixel_bus_t;

   typedef struct packed {
      logic supported;
      logic [6:0] word_bits;
      logic [3:0] pixels;
      logic [12:0] max_line;
   } fmt_info_t;

   // Format code to bus layout; even lines of 4:2:0 carry fewer pixels
   function automatic fmt_info_t fmt_lookup(input logic [5:0] code, input logic even);
      fmt_info_t f;
      f = '{1'b1, 7'h40, 4'h8, 13'h1680};
      unique casez (code)
         6'h20: f = '{1'b1, 7'h30, 4'h4, 13'h0B40};
         6'h21: f = '{1'b1, 7'h3C, 4'h4, 13'h0B40};
         6'h22: f = '{1'b1, 7'h40, 4'h4, 13'h0B40};
         6'h23: f = '{1'b1, 7'h36, 4'h3, 13'h09FC};
         6'h24: f = '{1'b1, 7'h30, 4'h2, 13'h0780};
         6'h28: f = '{1'b1, 7'h30, 4'h8, 13'h1E00};
         6'h29: f = '{1'b1, 7'h38, 4'h8, 13'h19B0};
         6'h2A: f = '{1'b1, 7'h40, 4'h8, 13'h1680};
         6'h2B: f = '{1'b1, 7'h28, 4'h4, 13'h1200};
         6'h2C: f = '{1'b1, 7'h30, 4'h4, 13'h0F00};
         6'h2D: f = '{1'b1, 7'h38, 4'h4, 13'h0CD8};
         6'h18, 6'h1C: f = '{1'b1, 7'h40, even ? 4'h4 : 4'h8, 13'h0B40};
         6'h19, 6'h1D: f = '{1'b1, 7'h28, even ? 4'h2 : 4'h4, 13'h0900};
         6'h1A: f = '{1'b1, 7'h30, 4'h4, 13'h0F00};
         6'h1E: f = '{1'b1, 7'h40, 4'h4, 13'h0B40};
         6'h1F: f = '{1'b1, 7'h28, 4'h2, 13'h0900};
         6'b110???: f = '{1'b1, 7'h40, 4'h8, 13'h1680};
         default: f = '{1'b0, 7'h40, 4'h8, 13'h0000};
      endcase
      return f;
   endfunction

endpackage

/* tb/unpack_checker_assertions.sv */
// Concurrent checks on the ports of the receive pixel unpacker
`timescale 1ns/1ps
module unpack_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire pixel_unpack_pkg::lane_pins_t lane_pins,
   input wire pixel_unpack_pkg::pixel_bus_t pixel_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      psel && penable && pready;
   endsequence
   zero_wait_a: assert property (s_setup |=> s_answer)
      else $error("pready missing in first access cycle");
   ready_lone_a: assert property (pready |-> $past(psel && !penable))
      else $error("pready without a setup cycle");
   unmapped_err_a: assert property (pready && paddr > 12'h00C |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   read_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
      else $error("prdata nonzero outside a read");

   // ----------------------------------------
   // Pixel bus, lane entry and lane exit
   // ----------------------------------------
   valid_pulse_a: assert property (pixel_out.valid |=> !pixel_out.valid)
      else $error("valid longer than one cycle");
   valid_hs_a: assert property (pixel_out.valid |-> pixel_out.hsync)
      else $error("pixel word outside a line");
   pix_count_a: assert property (pixel_out.valid |-> pixel_out.pixels inside {4'h2, 4'h3, 4'h4, 4'h8})
      else $error("illegal pixel count");
   hs_entry_a: assert property ($rose(pixel_out.hsync) |-> $past(lane_pins.dat_lp, 8) == 2'h0)
      else $error("line started without settled LP-00");
   exit_low_a: assert property (lane_pins.dat_lp == 2'h3 [*8] |=> ##3 !pixel_out.hsync)
      else $error("hsync high after stop state");
endmodule

bind pixel_unpack unpack_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .lane_pins(lane_pins), .pixel_out(pixel_out));

/* tb/tx_model.sv */
// Transmitter model driving the clock and data lanes of the receiver
`timescale 1ns/1ps
module tx_model (
   output pixel_unpack_pkg::lane_pins_t pins
);
   bit run;
   initial begin
      pins = '{1'b0, 1'b0, 2'h3, 2'h3};
      run = 1'b0;
      // Odd offset keeps the link clock out of phase with pclk
      #3.3;
      forever #80 if (run) pins.link_clk = ~pins.link_clk;
   end

   // One burst of nb bits, MSB first; bad skips LP-01 on the data lane
   task automatic burst(input int nb, input logic [63:0] w, input bit bad);
      pins.clk_lp = 2'h1;
      #100 pins.clk_lp = 2'h0;
      // Prepare plus zero well beyond 300 ns before the clock runs
      #400 run = 1'b1;
      repeat (8) @(negedge pins.link_clk);
      if (!bad) pins.dat_lp = 2'h1;
      @(negedge pins.link_clk) pins.dat_lp = 2'h0;
      for (int i = nb - 1; i >= 0; i--) begin
         @(negedge pins.link_clk) pins.hs_data = w[i];
      end
      @(negedge pins.link_clk) pins.dat_lp = 2'h3;
      // A released line must not keep showing the last bit
      pins.hs_data = ~pins.hs_data;
      repeat (4) @(negedge pins.link_clk);
      run = 1'b0;
      pins.clk_lp = 2'h3;
   endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the receive pixel unpacker
`timescale 1ns/1ps
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   pixel_unpack_pkg::lane_pins_t lane_pins;
   pixel_unpack_pkg::pixel_bus_t pixel_out;
   int n_fail = 0;
   int check_count = 0;
   logic [132:0] exp_q[$];
   logic par = 1'b0;
   logic [20:0] tab [20];

   always #5 pclk = ~pclk;

   pixel_unpack i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lane_pins(lane_pins), .pixel_out(pixel_out));
   tx_model i_tx (.pins(lane_pins));

   task automatic check(input string nm, input logic [67:0] seen, input logic [67:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Entered just after a rising edge; e and er are expected read data and error
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
         n++;
         @(posedge pclk);
      end
      if (!w) check("prdata", prdata, e);
      check("pslverr", pslverr, er);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Format is written between lines, while hsync is low
   task automatic send_line(input logic [5:0] c, input logic [6:0] b, input logic [3:0] px,
      input bit good, input bit bad);
      logic [63:0] w;
      logic [63:0] m;
      int n;
      w = {$urandom, $urandom};
      m = (64'h1 << b) - 64'h1;
      n = 0;
      apb(1'b1, pixel_unpack_pkg::ADDR_FORMAT, {26'h0, c}, 32'h0, 1'b0);
      if (good) exp_q.push_back({par, m, px, w & m});
      i_tx.burst(int'(b), w, bad);
      if (!bad) par = ~par;
      @(posedge pclk);
      while (pixel_out.hsync !== 1'b0 && n < 100) begin
         n++;
         @(posedge pclk);
      end
      $display("line with code %h done", c);
   endtask

   always @(posedge pclk) begin
      logic [132:0] e;
      if (pixel_out.valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("spurious word", 68'h1, 68'h0);
         end else begin
            e = exp_q.pop_front();
            check("word", {pixel_out.pixels, pixel_out.data & e[131:68]}, e[67:0]);
            check("parity", {67'h0, pixel_out.even_line}, {67'h0, e[132]});
         end
      end
   end

   initial begin
      #600_000;
      n_fail++;
      $display("watchdog expired");
      complete_run();
   end

   initial begin
      int s;
      s = $urandom(32'h0027BE61);
      tab = '{{6'h20, 7'h30, 8'h44}, {6'h21, 7'h3C, 8'h44}, {6'h22, 7'h40, 8'h44},
         {6'h23, 7'h36, 8'h33}, {6'h24, 7'h30, 8'h22}, {6'h28, 7'h30, 8'h88},
         {6'h29, 7'h38, 8'h88}, {6'h2A, 7'h40, 8'h88}, {6'h2B, 7'h28, 8'h44},
         {6'h2C, 7'h30, 8'h44}, {6'h2D, 7'h38, 8'h44}, {6'h18, 7'h40, 8'h84},
         {6'h1C, 7'h40, 8'h84}, {6'h19, 7'h28, 8'h42}, {6'h1D, 7'h28, 8'h42},
         {6'h1A, 7'h30, 8'h44}, {6'h1E, 7'h40, 8'h44}, {6'h1F, 7'h28, 8'h22},
         {6'h30, 7'h40, 8'h88}, {6'h37, 7'h40, 8'h88}};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, pixel_unpack_pkg::ADDR_FORMAT, 32'h0, 32'h0000002A, 1'b0);
      apb(1'b0, pixel_unpack_pkg::ADDR_CLK_SETTLE, 32'h0, 32'h000000C8, 1'b0);
      apb(1'b0, pixel_unpack_pkg::ADDR_DATA_SETTLE, 32'h0, 32'h00000091, 1'b0);
      apb(1'b1, pixel_unpack_pkg::ADDR_CLK_SETTLE, 32'h0000000A, 32'h0, 1'b0);
      apb(1'b0, pixel_unpack_pkg::ADDR_CLK_SETTLE, 32'h0, 32'h00000028, 1'b0);
      apb(1'b1, pixel_unpack_pkg::ADDR_CLK_SETTLE, 32'h00000FFF, 32'h0, 1'b0);
      apb(1'b0, pixel_unpack_pkg::ADDR_CLK_SETTLE, 32'h0, 32'h00000A1E, 1'b0);
      apb(1'b1, pixel_unpack_pkg::ADDR_CLK_SETTLE, 32'h000000C8, 32'h0, 1'b0);
      apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      apb(1'b0, pixel_unpack_pkg::ADDR_STATUS, 32'h0, 32'h00000001, 1'b0);
      $display("register test done");
      // Odd table positions fall on even lines
      foreach (tab[i]) send_line(tab[i][20:15], tab[i][14:8], i % 2 ? tab[i][3:0] : tab[i][7:4], 1, 0);
      send_line(6'h00, 7'h40, 4'h0, 1'b0, 1'b0);
      send_line(6'h2A, 7'h40, 4'h8, 1'b0, 1'b1);
      check("words left", 68'(exp_q.size()), 68'h0);
      complete_run();
   end
endmodule
